//--- core/mgac_pkg.sv
// Shared constants and types for the measurement gate and arming controller
package mgac_pkg;

   // ------------------------------------------------------------
   // Clock and arming delay timing
   // ------------------------------------------------------------
   localparam int          CLK_NS          = 25;
   localparam int          DELAY_UNIT_NS   = 100;
   localparam int          DELAY_TICK_CYC  = (DELAY_UNIT_NS + CLK_NS - 1)
                                             / CLK_NS;
   localparam int          DELAY_MIN_NS    = 200;
   localparam logic [23:0] DELAY_MIN_UNITS = 24'(DELAY_MIN_NS
                                             / DELAY_UNIT_NS);
   localparam longint      DELAY_MAX_NS    = 64'd1_670_000_000;
   localparam logic [23:0] DELAY_MAX_UNITS = 24'(DELAY_MAX_NS
                                             / DELAY_UNIT_NS);

   // ------------------------------------------------------------
   // Gate duration table
   // ------------------------------------------------------------
   localparam int          CNT_W          = 40;
   localparam logic [39:0] SLOW_DISC_NS   = 40'd800;
   localparam logic [39:0] FAST_DISC_NS   = 40'd80;
   localparam logic [4:0]  NUM_DISC       = 5'd5;
   localparam logic [39:0] CONT_FIRST_NS  = 40'd20_000;
   localparam logic [39:0] GATE_MAX_NS    = 40'd400_000_000_000;
   localparam logic [4:0]  PRESET_IDX_SLW = 5'd16;
   localparam logic [4:0]  PRESET_IDX_FST = 5'd17;
   localparam logic [4:0]  MAX_IDX_SLW    = 5'd26;
   localparam logic [4:0]  MAX_IDX_FST    = 5'd27;

   // ------------------------------------------------------------
   // Display and single-cycle figures
   // ------------------------------------------------------------
   localparam logic [3:0]  MAX_BLANK      = 4'd10;
   localparam logic [4:0]  FREQ_A_PERIODS = 5'd2;
   localparam logic [4:0]  FREQ_C_PERIODS = 5'd16;
   localparam logic [4:0]  ONE_PERIOD     = 5'd1;

   typedef enum logic [3:0] {
      FN_FREQ_A = 4'h0, FN_FREQ_B = 4'h1, FN_FREQ_C = 4'h2,
      FN_PERIOD = 4'h3, FN_PWIDTH = 4'h4, FN_RATIO  = 4'h5,
      FN_DUTY   = 4'h6, FN_PHASE  = 4'h7, FN_TOTAL  = 4'h8,
      FN_TIME   = 4'h9, FN_BURST  = 4'ha,
      FN_PULSE_REPETITION = 4'hb, FN_VOLTAGE = 4'hc
   } mgac_func_e;

   typedef enum logic [1:0] {
      SLOPE_OFF = 2'h0, SLOPE_POS = 2'h1, SLOPE_NEG = 2'h2
   } mgac_slope_e;

   typedef enum logic [1:0] {
      DLY_OFF = 2'h0, DLY_TIME = 2'h1, DLY_EVENTS = 2'h2
   } mgac_dly_e;

   typedef enum logic [6:0] {
      ST_RESULT  = 7'h01, ST_HOLDOFF = 7'h02, ST_PREP = 7'h04,
      ST_ARM     = 7'h08, ST_DELAY   = 7'h10, ST_TRIG = 7'h20,
      ST_GATE    = 7'h40
   } mgac_state_e;

endpackage

//--- core/mgac_arm_edge.sv
// Qualifier synchroniser and start/stop slope detector
`timescale 1ns/100ps
module mgac_arm_edge
   import mgac_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Qualifier level and slope choices
   input  wire logic       armIn,
   input  wire logic [1:0] startSlope,
   input  wire logic [1:0] stopSlope,
   // Detected qualifier edges
   output logic            startEdge,
   output logic            stopEdge
);
   logic [2:0] sync_reg, sync_next;
   logic       startEdge_next, stopEdge_next;
   logic       rise, fall;

   always_comb begin
      sync_next = {sync_reg[1:0], armIn};
      // Only the second and third stages are examined
      rise = sync_reg[1] & ~sync_reg[2]; // R26
      fall = ~sync_reg[1] & sync_reg[2];
      startEdge_next = (startSlope == SLOPE_POS) ? rise :
                       (startSlope == SLOPE_NEG) ? fall : 1'b0; // R12
      stopEdge_next  = (stopSlope == SLOPE_POS) ? rise :
                       (stopSlope == SLOPE_NEG) ? fall : 1'b0; // R12
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg  <= 3'h0;
         startEdge <= 1'b0;
         stopEdge  <= 1'b0;
      end else begin
         sync_reg  <= sync_next;
         startEdge <= startEdge_next;
         stopEdge  <= stopEdge_next;
      end
   end
endmodule

//--- core/mgac_gate_rom.sv
// Gate duration step table with registered cycle count
`timescale 1ns/100ps
module mgac_gate_rom
   import mgac_pkg::*;
#(
   parameter bit FAST_VARIANT = 1'b0
)
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Selection
   input  wire logic [4:0]  stepIdx,
   input  wire logic        useCustom,
   input  wire logic [39:0] customNs,
   // Gate length in clock cycles
   output logic [39:0]      gateCycles
);
   logic [39:0] ns, cyc, cyc_next;

   function automatic logic [39:0] step_ns(input logic [4:0] idx);
      logic [39:0] v;
      logic [1:0]  m;
      int          c;
      v = 40'h0;
      m = 2'd2;
      c = 0;
      if (idx < NUM_DISC) begin
         // Discrete steps double from the base
         v = (FAST_VARIANT ? FAST_DISC_NS : SLOW_DISC_NS) << idx; // R3 R4
      end else begin
         c = int'(idx - NUM_DISC) + (FAST_VARIANT ? 0 : 1);
         v = CONT_FIRST_NS;
         for (int i = 0; i < 32; i++) begin
            if (i < c) begin
               // 2 -> 5 -> 10 -> 20 in each decade
               if (m == 2'd2) begin
                  v = 40'((v >> 1) * 40'd5); // R2
                  m = 2'd0;
               end else begin
                  v = v << 1;
                  m = m + 2'd1;
               end
            end
         end
         if (v > GATE_MAX_NS)
            v = GATE_MAX_NS; // R3 R4
      end
      return v;
   endfunction

   always_comb begin
      ns  = useCustom ? customNs : step_ns(stepIdx);
      // Shortest gate rounds up to whole cycles
      cyc = 40'((ns + 40'(CLK_NS - 1)) / 40'(CLK_NS));
      cyc_next = (cyc == 40'h0) ? 40'h1 : cyc;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         gateCycles <= 40'h1;
      else
         gateCycles <= cyc_next;
   end
endmodule

//--- core/mgac_gate_ctrl.sv
// Gate timing, arming and hold control of a reciprocal counter
// Operation
// R1: Preset gate duration is 200 ms
// R2: Continuous steps 1/2/5, fast end discrete
// R3: Slow variant 800 ns to 400 s; loaded nonzero times below 800 ns are kept
// R4: Fast variant 80 ns to 400 s; loaded nonzero times below 80 ns are kept
// R5: Single mode: gate setting is holdoff
// R6: Zero request flags error, offers minimum
// R7: Gate flag high exactly while counting
// R8: Average normally, one cycle in single
// R9: Single mode period count per function
// R10: Hold finishes current, then stops
// R11: Restart begins one new measurement
// R12: Start/stop qualifier: rise, fall, off
// R13: Qualifier from rear input or channel B
// R14: Optional start delay by time or events
// R15: No start arming for burst, repetition, voltage
// R16: Start qualifier gates first sample only
// R17: Stop qualifier must precede measurement end
// R18: Stop arming only freq/period/ratio/totalize
// R19: Blank zero to ten trailing digits
// R20: Gate edges align to input triggers
// R21: Ordered start conditions, auto repeat
// R22: End on first trigger after gate
// R23: Start arming requires edge each measurement
// R24: Delay 200 ns to 1.67 s, 100 ns
// R25: Count events and reference, latch both
// R26: Qualifier synchronised before edge detection
`timescale 1ns/100ps
module mgac_gate_ctrl
   import mgac_pkg::*;
#(
   parameter bit FAST_VARIANT = 1'b0
)
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Gate time setting
   input  wire logic        timeUp,
   input  wire logic        timeDown,
   input  wire logic        timeLoad,
   input  wire logic [39:0] timeNs,
   input  wire logic        timeConfirm,
   // Measurement mode
   input  wire logic [3:0]  func,
   input  wire logic        singleMode,
   input  wire logic        holdReq,
   input  wire logic        restartReq,
   // Arming setup and digit blanking
   input  wire logic [1:0]  startSlope,
   input  wire logic [1:0]  stopSlope,
   input  wire logic        armSrcB,
   input  wire logic [1:0]  delayMode,
   input  wire logic [23:0] delaySetting,
   input  wire logic [3:0]  blankReq,
   // Measured channels and arming input
   input  wire logic        armInE,
   input  wire logic        chanBIn,
   input  wire logic        inTrig,
   input  wire logic        inEvent,
   // Result processing handshake
   input  wire logic        prepReady,
   input  wire logic        resultTaken,
   // Status and results
   output logic             gateActive,
   output logic             resultValid,
   output logic [39:0]      evCount,
   output logic [39:0]      refCount,
   output logic             rangeErr,
   output logic             holdActive,
   output logic [3:0]       blankDigits,
   output logic [4:0]       singlePeriods,
   output logic             compositeMeas
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   mgac_state_e state_reg, state_next;
   logic [4:0]  stepIdx_reg, stepIdx_next, maxIdx, presetIdx;
   logic        custom_reg, custom_next;
   logic [39:0] customNs_reg, customNs_next, gateCycles;
   logic [39:0] timer_reg, timer_next, evRun_reg, evRun_next;
   logic [39:0] refRun_reg, refRun_next;
   logic [23:0] dly_reg, dly_next;
   logic [1:0]  tick_reg, tick_next;
   logic [4:0]  trigCnt_reg, trigCnt_next, needPer;
   logic        holdOn_reg, holdOn_next, pend_reg, pend_next;
   logic        stopSeen_reg, stopSeen_next, rangeErr_next;
   logic        gateActive_next, resultValid_next, composite_next;
   logic [39:0] evCount_next, refCount_next;
   logic [3:0]  blank_next;
   logic        startEdge, stopEdge, tick, effSingle;
   logic        startArmOk, stopArmOk, gateEnd, leavePrep;

   generate
      if (DELAY_TICK_CYC != 4)
         $error("Delay tick divider assumes four clocks per unit");
   endgenerate

   assign maxIdx    = FAST_VARIANT ? MAX_IDX_FST : MAX_IDX_SLW;
   assign presetIdx = FAST_VARIANT ? PRESET_IDX_FST : PRESET_IDX_SLW;

   // ------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------
   mgac_arm_edge u_edge (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .armIn      (armSrcB ? chanBIn : armInE), // R13
      .startSlope (startSlope),
      .stopSlope  (stopSlope),
      .startEdge  (startEdge),
      .stopEdge   (stopEdge)
   );

   mgac_gate_rom #(.FAST_VARIANT(FAST_VARIANT)) u_rom (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .stepIdx    (stepIdx_reg),
      .useCustom  (custom_reg),
      .customNs   (customNs_reg),
      .gateCycles (gateCycles)
   );

   // ------------------------------------------------------------
   // Mode decoding
   // ------------------------------------------------------------
   always_comb begin
      // Peak voltage functions ignore single mode
      effSingle = singleMode && (func != FN_VOLTAGE); // R8 R9
      startArmOk = (startSlope != SLOPE_OFF) &&
                   (func != FN_BURST) &&
                   (func != FN_PULSE_REPETITION) &&
                   (func != FN_VOLTAGE); // R15
      stopArmOk = (stopSlope != SLOPE_OFF) &&
                  ((func == FN_FREQ_A) || (func == FN_FREQ_B) ||
                   (func == FN_FREQ_C) || (func == FN_PERIOD) ||
                   (func == FN_RATIO)  || (func == FN_TOTAL)); // R18
      case (func)
         FN_FREQ_A: needPer = FREQ_A_PERIODS; // R9
         FN_FREQ_C: needPer = FREQ_C_PERIODS; // R9
         default:   needPer = ONE_PERIOD;     // R9
      endcase
      composite_next = effSingle &&
                       ((func == FN_DUTY) || (func == FN_PHASE)); // R9
      tick = (tick_reg == 2'(DELAY_TICK_CYC - 1));
      tick_next = tick ? 2'h0 : tick_reg + 2'h1;
      // Stop only on an input trigger, after time or in single
      gateEnd = inTrig && (stopSeen_reg || !stopArmOk) &&
                (effSingle ? (trigCnt_reg + 5'h1 >= needPer)
                           : (timer_reg == 40'h0)); // R22 R17 R20
   end

   // ------------------------------------------------------------
   // Settings: gate time, hold, blanking
   // ------------------------------------------------------------
   always_comb begin
      stepIdx_next  = stepIdx_reg;
      custom_next   = custom_reg;
      customNs_next = customNs_reg;
      rangeErr_next = rangeErr;
      if (timeUp && stepIdx_reg < maxIdx) begin
         stepIdx_next = stepIdx_reg + 5'h1; // R2
         custom_next  = 1'b0;
      end else if (timeDown && stepIdx_reg != 5'h0) begin
         stepIdx_next = stepIdx_reg - 5'h1; // R2
         custom_next  = 1'b0;
      end
      if (timeConfirm && rangeErr) begin
         // Accepting the offer applies the shortest step
         stepIdx_next  = 5'h0; // R6
         custom_next   = 1'b0;
         rangeErr_next = 1'b0;
      end
      if (timeLoad) begin
         if (timeNs == 40'h0) begin
            rangeErr_next = 1'b1; // R6
         end else begin
            custom_next   = 1'b1;
            customNs_next = (timeNs > GATE_MAX_NS) ? GATE_MAX_NS
                                                   : timeNs;
            rangeErr_next = 1'b0;
         end
      end
      holdOn_next = holdReq ? ~holdOn_reg : holdOn_reg; // R10
      // Restart request wins over consumption
      pend_next = restartReq ? 1'b1 :
                  (leavePrep ? 1'b0 : pend_reg); // R11
      blank_next = (blankReq > MAX_BLANK) ? MAX_BLANK : blankReq; // R19
   end

   // ------------------------------------------------------------
   // Measurement sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_next       = state_reg;
      timer_next       = timer_reg;
      dly_next         = dly_reg;
      trigCnt_next     = trigCnt_reg;
      evRun_next       = evRun_reg;
      refRun_next      = refRun_reg;
      stopSeen_next    = stopSeen_reg;
      evCount_next     = evCount;
      refCount_next    = refCount;
      resultValid_next = 1'b0;
      leavePrep        = 1'b0;
      case (state_reg)
         ST_RESULT: begin
            if (resultTaken) begin // R21
               timer_next = gateCycles; // R5
               state_next = effSingle ? ST_HOLDOFF : ST_PREP;
            end
         end
         ST_HOLDOFF: begin
            if (timer_reg > 40'h1)
               timer_next = timer_reg - 40'h1;
            else
               state_next = ST_PREP; // R5 R21
         end
         ST_PREP: begin
            if (prepReady && (!holdOn_reg || pend_reg)) begin // R21 R10
               leavePrep  = 1'b1;
               state_next = startArmOk ? ST_ARM : ST_TRIG; // R23
            end
         end
         ST_ARM: begin
            if (startEdge) begin // R23 R16
               dly_next = (delaySetting < DELAY_MIN_UNITS) ?
                          DELAY_MIN_UNITS :
                          (delaySetting > DELAY_MAX_UNITS) ?
                          DELAY_MAX_UNITS : delaySetting; // R24
               state_next = (delayMode == DLY_OFF) ? ST_TRIG
                                                   : ST_DELAY; // R14
            end
         end
         ST_DELAY: begin
            if (dly_reg == 24'h0)
               state_next = ST_TRIG; // R14
            else if ((delayMode == DLY_TIME) ? tick : inEvent)
               dly_next = dly_reg - 24'h1; // R14 R24
         end
         ST_TRIG: begin
            if (inTrig) begin // R20 R21
               state_next    = ST_GATE;
               timer_next    = gateCycles; // R1
               trigCnt_next  = 5'h0;
               evRun_next    = 40'h0;
               refRun_next   = 40'h0;
               stopSeen_next = 1'b0;
            end
         end
         ST_GATE: begin
            refRun_next = refRun_reg + 40'h1; // R25
            evRun_next  = evRun_reg + {39'h0, inEvent}; // R25
            if (timer_reg != 40'h0)
               timer_next = timer_reg - 40'h1; // R8
            if (stopEdge)
               stopSeen_next = 1'b1; // R17
            if (inTrig)
               trigCnt_next = trigCnt_reg + 5'h1; // R9
            if (gateEnd) begin
               evCount_next     = evRun_next; // R25
               refCount_next    = refRun_next; // R25
               resultValid_next = 1'b1;
               state_next       = ST_RESULT;
            end
         end
         default: state_next = ST_PREP;
      endcase
      gateActive_next = (state_next == ST_GATE); // R7
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_PREP;
         stepIdx_reg   <= FAST_VARIANT ? PRESET_IDX_FST
                                       : PRESET_IDX_SLW; // R1
         custom_reg    <= 1'b0;
         customNs_reg  <= 40'h0;
         rangeErr      <= 1'b0;
         holdOn_reg    <= 1'b0;
         pend_reg      <= 1'b0;
         timer_reg     <= 40'h0;
         dly_reg       <= 24'h0;
         tick_reg      <= 2'h0;
         trigCnt_reg   <= 5'h0;
         evRun_reg     <= 40'h0;
         refRun_reg    <= 40'h0;
         stopSeen_reg  <= 1'b0;
         gateActive    <= 1'b0;
         resultValid   <= 1'b0;
         evCount       <= 40'h0;
         refCount      <= 40'h0;
         holdActive    <= 1'b0;
         blankDigits   <= 4'h0;
         singlePeriods <= ONE_PERIOD;
         compositeMeas <= 1'b0;
      end else begin
         state_reg     <= state_next;
         stepIdx_reg   <= stepIdx_next;
         custom_reg    <= custom_next;
         customNs_reg  <= customNs_next;
         rangeErr      <= rangeErr_next;
         holdOn_reg    <= holdOn_next;
         pend_reg      <= pend_next;
         timer_reg     <= timer_next;
         dly_reg       <= dly_next;
         tick_reg      <= tick_next;
         trigCnt_reg   <= trigCnt_next;
         evRun_reg     <= evRun_next;
         refRun_reg    <= refRun_next;
         stopSeen_reg  <= stopSeen_next;
         gateActive    <= gateActive_next;
         resultValid   <= resultValid_next;
         evCount       <= evCount_next;
         refCount      <= refCount_next;
         holdActive    <= holdOn_next;
         blankDigits   <= blank_next;
         singlePeriods <= effSingle ? needPer : 5'h0;
         compositeMeas <= composite_next;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_gate_open;
      state_reg == ST_TRIG && inTrig;
   endsequence

   sequence s_gate_close;
      state_reg == ST_GATE ##1 state_reg == ST_RESULT;
   endsequence

   a_gate_flag: assert property ( // R7
      @(posedge sys_clk) disable iff (!rst_n)
      gateActive == (state_reg == ST_GATE))
      else $error("Gate flag does not match counting state");

   a_start_trig: assert property ( // R20
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(gateActive) |-> $past(inTrig))
      else $error("Gate opened without input trigger");

   a_stop_result: assert property ( // R25
      @(posedge sys_clk) disable iff (!rst_n)
      s_gate_close |-> resultValid && $past(inTrig))
      else $error("Gate closed without trigger and result");

   a_stop_armed: assert property ( // R17
      @(posedge sys_clk) disable iff (!rst_n)
      s_gate_close |-> $past(stopSeen_reg || !stopArmOk))
      else $error("Gate closed before stop qualifier");

   a_timed_gate: assert property ( // R22
      @(posedge sys_clk) disable iff (!rst_n)
      s_gate_close |-> $past(effSingle || timer_reg == 40'h0))
      else $error("Gate closed before gate time expired");

   a_hold_stays: assert property ( // R10
      @(posedge sys_clk) disable iff (!rst_n)
      state_reg == ST_PREP && holdOn_reg && !pend_reg
      |=> state_reg == ST_PREP)
      else $error("Measurement started while held");

   a_restart_pend: assert property ( // R11
      @(posedge sys_clk) disable iff (!rst_n)
      restartReq |=> pend_reg)
      else $error("Restart request lost");

   a_zero_error: assert property ( // R6
      @(posedge sys_clk) disable iff (!rst_n)
      timeLoad && timeNs == 40'h0 |=> rangeErr ##1 1'b1)
      else $error("Zero gate time not flagged");

   a_blank_limit: assert property ( // R19
      @(posedge sys_clk) disable iff (!rst_n)
      ##1 blankDigits == $past(blankReq > MAX_BLANK ?
                               MAX_BLANK : blankReq))
      else $error("Blank digit count wrong");

   a_arm_first: assert property ( // R23
      @(posedge sys_clk) disable iff (!rst_n)
      state_reg == ST_PREP && prepReady && startArmOk &&
      (!holdOn_reg || pend_reg) |=> state_reg == ST_ARM)
      else $error("Start arming skipped");

   a_open_count: assert property ( // R25
      @(posedge sys_clk) disable iff (!rst_n)
      s_gate_open |=> refRun_reg == 40'h0 ##1 refRun_reg == 40'h1
                      or state_reg == ST_RESULT)
      else $error("Reference counter did not start at gate");
endmodule

//--- testbench/mgac_src_model.sv
// Source model: input triggers, counted events and qualifier level
`timescale 1ns/100ps
module mgac_src_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Trigger spacing and qualifier level
   input  wire logic [3:0] period,
   input  wire logic       armLvl,
   // Signals towards the block
   output logic            inTrig,
   output logic            inEvent,
   output logic            armInE,
   output logic            chanBIn
);
   logic [3:0] cnt_reg, cnt_next;
   always_comb begin
      cnt_next = (cnt_reg >= period) ? 4'h0 : cnt_reg + 4'h1;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         cnt_reg <= 4'h0;
      else
         cnt_reg <= cnt_next;
   end
   // Periodic triggers; events high whenever the count is even
   assign inTrig  = (cnt_reg == 4'h0);
   assign inEvent = ~cnt_reg[0];
   assign armInE  = armLvl;
   assign chanBIn = cnt_reg[1];
endmodule

//--- testbench/test_mgac_gate_ctrl.sv
// Self-checking bench of the gate and arming controller
`timescale 1ns/100ps
module test_mgac_gate_ctrl
   import mgac_pkg::*;
;
   logic sys_clk = 0, rst_n = 0, timeUp = 0, timeDown = 0, timeLoad = 0;
   logic timeConfirm = 0, singleMode = 0, holdReq = 0, restartReq = 0;
   logic armSrcB = 0, prepReady = 0, resultTaken = 0, armLvl = 0;
   logic gateActive, resultValid, rangeErr, holdActive, compositeMeas;
   logic inTrig, inEvent, armInE, chanBIn;
   logic [39:0] timeNs = 0, evCount, refCount;
   logic [3:0]  func = 0, blankReq = 0, period = 3, blankDigits;
   logic [1:0]  startSlope = 0, stopSlope = 0, delayMode = 0;
   logic [23:0] delaySetting = 0;
   logic [4:0]  singlePeriods;
   int          n_fail = 0, cmp_count = 0, seed = 90, gateN = 0, g, w = 0;
   int          expQ[$];
   mgac_func_e  fl[5] = '{FN_FREQ_A, FN_FREQ_C, FN_PERIOD, FN_TOTAL, FN_DUTY};
   logic [4:0]  sp[5] = '{5'h02, 5'h10, 5'h01, 5'h01, 5'h01};

   mgac_gate_ctrl mgac_gate_ctrl_i (.sys_clk, .rst_n, .timeUp, .timeDown,
      .timeLoad, .timeNs, .timeConfirm, .func, .singleMode, .holdReq,
      .restartReq, .startSlope, .stopSlope, .armSrcB, .delayMode,
      .delaySetting, .blankReq, .armInE, .chanBIn, .inTrig, .inEvent,
      .prepReady, .resultTaken, .gateActive, .resultValid, .evCount,
      .refCount, .rangeErr, .holdActive, .blankDigits, .singlePeriods,
      .compositeMeas);
   mgac_src_model mgac_src_model_i (.sys_clk, .rst_n, .period, .armLvl,
      .inTrig, .inEvent, .armInE, .chanBIn);

   always #12.5 sys_clk = ~sys_clk;

   task automatic chk(string nm, logic [39:0] e, logic [39:0] v);
      cmp_count++;
      if (v !== e) begin
         n_fail++;
         $display("mismatch %s exp %0h got %0h", nm, e, v);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask
   // Notes the minimum gate, then waits for the result under a bound
   task automatic waitRes(int gmin);
      int k;
      k = 0;
      expQ.push_back(gmin);
      while (resultValid !== 1'b1 && k < 3000) begin
         cyc(1);
         k++;
      end
      chk("resultValid", 40'h1, 40'(resultValid));
      cyc(1);
   endtask
   task summarize;
      if (n_fail == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Result monitor
   // ----------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (gateActive === 1'b1) gateN++;
      if (resultValid === 1'b1) begin
         if (expQ.size() > 0) begin
            g = expQ.pop_front();
            chk("gateLen", 40'h1, 40'(gateN >= g && gateN <= g + 8));
            chk("refCount", 40'(gateN), refCount);
            chk("evCount", 40'h1, 40'(evCount * 2 + 3 >= 40'(gateN)));
         end
         gateN = 0;
      end
      resultTaken <= #2 resultValid;
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      cyc(10);
      rst_n = 1'b1;
      period = 4'(($random(seed) & 3) + 3);
      chk("rangeErr", 40'h0, 40'(rangeErr));
      chk("holdActive", 40'h0, 40'(holdActive));
      pulse(timeLoad);
      cyc(1);
      chk("rangeErr", 40'h1, 40'(rangeErr));
      pulse(timeConfirm);
      cyc(1);
      chk("rangeErr", 40'h0, 40'(rangeErr));
      pulse(timeUp);
      cyc(3);
      prepReady = 1'b1;
      waitRes(64);
      prepReady = 1'b0;
      timeNs = 40'hfa;
      pulse(timeLoad);
      cyc(3);
      prepReady = 1'b1;
      waitRes(10);
      singleMode = 1'b1;
      prepReady = 1'b0;
      cyc(20);
      for (int i = 0; i < 5; i++) begin
         func = fl[i];
         cyc(3);
         chk("singlePeriods", 40'(sp[i]), 40'(singlePeriods));
         chk("compositeMeas", 40'(i == 4), 40'(compositeMeas));
      end
      for (int i = 0; i < 6; i++) begin
         blankReq = (i == 0) ? 4'hc : 4'($random(seed));
         cyc(2);
         chk("blankDigits", blankReq > 10 ? 40'ha : 40'(blankReq),
             40'(blankDigits));
      end
      singleMode = 1'b0;
      func = FN_FREQ_A;
      prepReady = 1'b1;
      for (int k = 0; k < 400 && gateActive !== 1'b1; k++) cyc(1);
      pulse(holdReq);
      chk("holdActive", 40'h1, 40'(holdActive));
      waitRes(10);
      cyc(150);
      chk("gateN", 40'h0, 40'(gateN));
      pulse(restartReq);
      waitRes(10);
      cyc(150);
      chk("gateN", 40'h0, 40'(gateN));
      pulse(holdReq);
      startSlope = SLOPE_POS;
      cyc(100);
      chk("gateN", 40'h0, 40'(gateN));
      armLvl = 1'b1;
      waitRes(10);
      startSlope = SLOPE_NEG;
      cyc(20);
      armLvl = 1'b0;
      waitRes(10);
      func = FN_BURST;
      startSlope = SLOPE_POS;
      waitRes(10);
      // Stop qualifier rises well after the gate time has run out
      func = FN_PERIOD;
      startSlope = SLOPE_OFF;
      stopSlope = SLOPE_POS;
      for (int k = 0; k < 400 && gateActive !== 1'b1; k++) cyc(1);
      cyc(38);
      armLvl = 1'b1;
      waitRes(42);
      func = FN_PWIDTH;
      waitRes(10);
      // Start from channel B, delayed by 50 units of 100 ns
      armSrcB = 1'b1;
      startSlope = SLOPE_POS;
      delayMode = DLY_TIME;
      delaySetting = 24'h32;
      pulse(timeDown);
      while (gateActive !== 1'b1 && w < 400) begin
         cyc(1);
         w++;
      end
      chk("armDelay", 40'h1, 40'(w >= 200 && w <= 240));
      waitRes(32);
      delayMode = DLY_OFF;
      singleMode = 1'b1;
      func = FN_FREQ_A;
      waitRes(8);
      summarize();
   end

   initial begin
      #(25 * 40000);
      n_fail++;
      summarize();
   end
endmodule
